//--- way_lock_pkg.sv
package way_lock_pkg;

  // Cache control register field positions.
  localparam int unsigned CACHE_ENABLE_BIT        = 31;
  localparam int unsigned RESERVED_TOP_BIT        = 30;
  localparam int unsigned STORE_BUFFER_ENABLE_BIT = 29;
  localparam int unsigned PUSH_KEEPS_VALID_BIT    = 28;
  localparam int unsigned HALF_WAY_LOCK_BIT       = 27;

  // Writable bits of the upper control field; all others read as zero.
  localparam logic [31:0] CONTROL_WRITE_MASK = 32'hB800_0000;
  localparam logic [31:0] CONTROL_RESET      = 32'h0000_0000;

  // Geometry of the cache and its buffers.
  localparam int unsigned NUM_WAYS            = 4;
  localparam int unsigned STORE_DEPTH         = 4;
  localparam int unsigned STORE_ENTRY_BYTES   = 4;
  localparam int unsigned PUSH_LINE_BYTES     = 16;

  // Way numbers used by the allocation policy.
  localparam logic [1:0] WAY_0 = 2'h0;
  localparam logic [1:0] WAY_1 = 2'h1;
  localparam logic [1:0] WAY_2 = 2'h2;
  localparam logic [1:0] WAY_3 = 2'h3;

  // Round-robin counter reset value.
  localparam logic [1:0] ROUND_ROBIN_RESET = 2'h0;

endpackage : way_lock_pkg

//--- victim_select.sv
`timescale 1ns/1ps
`default_nettype none

// Combinational victim choice and next round-robin value for one allocation.
module victim_select
  import way_lock_pkg::*;
(
  input  wire logic [3:0] way_valid,
  input  wire logic       locked,
  input  wire logic [1:0] round_robin,
  output var  logic [1:0] victim,
  output var  logic [1:0] round_robin_next
);

  // Picks the way to fill and how the counter advances.
  always_comb begin
    victim           = WAY_0;
    round_robin_next = round_robin;
    if (locked) begin
      // Ways 0 and 1 are never candidates here.
      if (!way_valid[WAY_2]) begin
        victim = WAY_2;
      end else if (!way_valid[WAY_3]) begin
        victim = WAY_3;
      end else if (!round_robin[1]) begin
        victim = WAY_2;
      end else begin
        victim           = WAY_3;
        round_robin_next = {round_robin[1], ~round_robin[0]};
      end
    end else begin
      if (!way_valid[WAY_0]) begin
        victim = WAY_0;
      end else if (!way_valid[WAY_1]) begin
        victim = WAY_1;
      end else if (!way_valid[WAY_2]) begin
        victim = WAY_2;
      end else if (!way_valid[WAY_3]) begin
        victim = WAY_3;
      end else begin
        victim           = round_robin;
        round_robin_next = round_robin + 2'h1;
      end
    end
  end

endmodule : victim_select

`default_nettype wire

//--- store_path_select.sv
`timescale 1ns/1ps
`default_nettype none

// Decides whether a core write is deferred into the store buffer or goes to the bus.
module store_path_select (
  input  wire logic store_buffer_enable,
  input  wire logic imprecise,
  input  wire logic write_through,
  input  wire logic inhibited,
  output var  logic use_store_buffer
);

  // Only imprecise write-through or inhibited writes are deferred.
  always_comb begin
    use_store_buffer = store_buffer_enable && imprecise && (write_through || inhibited);
  end

endmodule : store_path_select

`default_nettype wire

//--- cache_way_lock_and_control.sv
`timescale 1ns/1ps
`default_nettype none

module cache_way_lock_and_control
  import way_lock_pkg::*;
#(
  parameter int unsigned STORE_ENTRIES = STORE_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // Control register move from the core.
  input  wire logic        ctl_move_write,
  input  wire logic [31:0] ctl_move_data,
  // Debug facility access.
  input  wire logic        debug_write,
  input  wire logic [31:0] debug_wdata,
  output logic      [31:0] debug_rdata,
  // Allocation request: state of the addressed set.
  input  wire logic        alloc_req,
  input  wire logic [3:0]  alloc_valid,
  output logic             alloc_ack,
  output logic      [1:0]  alloc_way,
  // Write hit on a way.
  input  wire logic        write_hit,
  input  wire logic [1:0]  write_hit_way,
  input  wire logic        write_hit_copyback,
  output logic             hit_update,
  output logic      [1:0]  hit_update_way,
  output logic             hit_set_modified,
  // Explicit line push instruction.
  input  wire logic        push_req,
  input  wire logic [1:0]  push_way,
  input  wire logic        push_modified,
  output logic             push_writeback,
  output logic             push_invalidate,
  output logic      [1:0]  push_out_way,
  // Eviction of a modified victim during replacement.
  input  wire logic        victim_modified,
  input  wire logic        fill_done,
  input  wire logic        push_bus_done,
  output logic             push_buffer_valid,
  output logic             push_buffer_write,
  // Core writes and the store buffer.
  input  wire logic        core_write,
  input  wire logic        write_imprecise,
  input  wire logic        write_through,
  input  wire logic        write_inhibited,
  input  wire logic        store_retire,
  output logic             store_enqueue,
  output logic             direct_bus_write,
  output logic             core_stall,
  output logic      [2:0]  store_count,
  // Control bits seen by the rest of the cache.
  output logic             cache_enable,
  output logic             store_buffer_enable,
  output logic             push_keeps_line_valid,
  output logic             half_way_lock
);

  ////////////////////////////////////////////////////////////////////////////
  // Control register.

  logic [31:0] cache_control_reg;   // Upper control bits.
  logic [1:0]  round_robin_reg;     // Victim counter.
  logic [1:0]  victim;              // Chosen way.
  logic [1:0]  round_robin_next;    // Advanced counter.
  logic        use_store_buffer;    // Write is deferrable.
  logic        store_full;          // No room in store buffer.
  logic [2:0]  store_count_reg;     // Entries held.
  logic        pending_evict_reg;   // Modified victim awaiting fill.
  logic        alloc_taken;         // Allocation accepted this cycle.
  logic        hit_taken;           // Write hit accepted this cycle.
  logic        evict_start;         // Modified victim enters the push buffer.
  logic        enqueue_ok;          // Core write goes into the store buffer.
  logic        push_done;           // Line write of the push buffer finished.

  // A request counts only while the cache is switched on.
  // A disabled cache keeps its contents but answers no allocation or write hit.
  function automatic logic enabled_req(input logic req, input logic enable);
    return req && enable;
  endfunction : enabled_req

  // Qualified requests shared by several processes below.
  // Working them out once keeps the processes from drifting apart.
  always_comb begin
    alloc_taken = enabled_req(alloc_req, cache_enable);
    hit_taken   = enabled_req(write_hit, cache_enable);
    evict_start = alloc_taken && victim_modified && !push_buffer_valid;
    enqueue_ok  = core_write && use_store_buffer && !store_full;
    push_done   = push_buffer_write && push_bus_done;
  end

  // Bit 30 is masked so a stray write cannot set it.
  always_ff @(posedge clk) begin
    if (rst) begin
      cache_control_reg <= CONTROL_RESET;
    end else if (debug_write) begin
      cache_control_reg <= debug_wdata & CONTROL_WRITE_MASK;
    end else if (ctl_move_write) begin
      cache_control_reg <= ctl_move_data & CONTROL_WRITE_MASK;
    end
  end

  // Control bits and read-back come straight from flip-flops.
  always_comb begin
    debug_rdata           = cache_control_reg;
    cache_enable          = cache_control_reg[CACHE_ENABLE_BIT];
    store_buffer_enable   = cache_control_reg[STORE_BUFFER_ENABLE_BIT];
    push_keeps_line_valid = cache_control_reg[PUSH_KEEPS_VALID_BIT];
    half_way_lock         = cache_control_reg[HALF_WAY_LOCK_BIT];
    store_count           = store_count_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Allocation.

  victim_select u_victim (
    .way_valid        (alloc_valid),
    .locked           (half_way_lock),
    .round_robin      (round_robin_reg),
    .victim           (victim),
    .round_robin_next (round_robin_next)
  );

  // Answers an accepted request one cycle later.
  // The lock is sampled at each request, so it may change at any time.
  always_ff @(posedge clk) begin
    if (rst) begin
      alloc_ack <= 1'b0;
    end else begin
      alloc_ack <= alloc_taken;
    end
  end

  // Holds the way chosen for the last accepted request.
  // Under the lock the choice never falls on way 0 or way 1.
  always_ff @(posedge clk) begin
    if (rst) begin
      alloc_way <= WAY_0;
    end else if (alloc_taken) begin
      alloc_way <= victim;
    end
  end

  // Advances the victim counter only on an accepted allocation.
  // A refused request leaves the counter frozen.
  always_ff @(posedge clk) begin
    if (rst) begin
      round_robin_reg <= ROUND_ROBIN_RESET;
    end else if (alloc_taken) begin
      round_robin_reg <= round_robin_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write hits and explicit pushes.

  // Any way, locked or not, is updated on a hit.
  always_ff @(posedge clk) begin
    if (rst) begin
      hit_update <= 1'b0;
    end else begin
      hit_update <= hit_taken;
    end
  end

  // Passes the hit way on with the update strobe.
  always_ff @(posedge clk) begin
    if (rst) begin
      hit_update_way <= WAY_0;
    end else begin
      hit_update_way <= write_hit_way;
    end
  end

  // Copyback hits mark the line modified, locked ways included.
  always_ff @(posedge clk) begin
    if (rst) begin
      hit_set_modified <= 1'b0;
    end else begin
      hit_set_modified <= hit_taken && write_hit_copyback;
    end
  end

  // Explicit push works on any way, including locked ones.
  // Only a modified line is written back.
  always_ff @(posedge clk) begin
    if (rst) begin
      push_writeback <= 1'b0;
    end else begin
      push_writeback <= push_req && push_modified;
    end
  end

  // The line is dropped after a push unless the keep bit is set.
  always_ff @(posedge clk) begin
    if (rst) begin
      push_invalidate <= 1'b0;
    end else begin
      push_invalidate <= push_req && !push_keeps_line_valid;
    end
  end

  // Passes the pushed way on with the answer.
  always_ff @(posedge clk) begin
    if (rst) begin
      push_out_way <= WAY_0;
    end else begin
      push_out_way <= push_way;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Push buffer for a displaced modified line.

  // The line waits until the fill completes, then is written out once.
  // A second modified victim is ignored while the buffer is busy.
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_evict_reg <= 1'b0;
    end else if (evict_start) begin
      pending_evict_reg <= 1'b1;
    end else if (pending_evict_reg && fill_done) begin
      pending_evict_reg <= 1'b0;
    end
  end

  // The buffer holds the line from eviction until its write ends.
  always_ff @(posedge clk) begin
    if (rst) begin
      push_buffer_valid <= 1'b0;
    end else if (evict_start) begin
      push_buffer_valid <= 1'b1;
    end else if (push_done) begin
      push_buffer_valid <= 1'b0;
    end
  end

  // The line write is asked for only once the fill has ended.
  // This keeps the fetch of the new line ahead of the write-back.
  always_ff @(posedge clk) begin
    if (rst) begin
      push_buffer_write <= 1'b0;
    end else if (pending_evict_reg && fill_done) begin
      push_buffer_write <= 1'b1;
    end else if (push_done) begin
      push_buffer_write <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Store buffer occupancy.

  store_path_select u_store_path (
    .store_buffer_enable (store_buffer_enable),
    .imprecise           (write_imprecise),
    .write_through       (write_through),
    .inhibited           (write_inhibited),
    .use_store_buffer    (use_store_buffer)
  );

  assign store_full = (store_count_reg == 3'(STORE_ENTRIES));

  // Counts entries of at most one word each; retire frees a slot.
  // An entry in and an entry out in one cycle leave the count alone.
  always_ff @(posedge clk) begin
    if (rst) begin
      store_count_reg <= 3'h0;
    end else begin
      case ({enqueue_ok, store_retire && (store_count_reg != 3'h0)})
        // One more entry waits for the bus.
        2'b10:   store_count_reg <= store_count_reg + 3'h1;
        // The bus has taken the oldest entry.
        2'b01:   store_count_reg <= store_count_reg - 3'h1;
        default: store_count_reg <= store_count_reg;
      endcase
    end
  end

  // Flags a write that was placed in the store buffer.
  always_ff @(posedge clk) begin
    if (rst) begin
      store_enqueue <= 1'b0;
    end else begin
      store_enqueue <= enqueue_ok;
    end
  end

  // Flags a write that goes straight to the bus.
  // Precise inhibited writes always land here.
  always_ff @(posedge clk) begin
    if (rst) begin
      direct_bus_write <= 1'b0;
    end else begin
      direct_bus_write <= core_write && !use_store_buffer;
    end
  end

  // Stalls the core while a deferrable write finds the buffer full.
  always_ff @(posedge clk) begin
    if (rst) begin
      core_stall <= 1'b0;
    end else begin
      core_stall <= core_write && use_store_buffer && store_full;
    end
  end

endmodule : cache_way_lock_and_control

`default_nettype wire

//--- way_ctl_props.sv
`timescale 1ns/1ps
`default_nettype none
// Watches allocation, register and write-path answers of the control block.
module way_ctl_props
  import way_lock_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        alloc_req,
  input wire logic        alloc_ack,
  input wire logic        cache_enable,
  input wire logic        half_way_lock,
  input wire logic [3:0]  alloc_valid,
  input wire logic [1:0]  alloc_way,
  input wire logic [1:0]  write_hit_way,
  input wire logic [1:0]  hit_update_way,
  input wire logic [31:0] debug_rdata,
  input wire logic        write_hit,
  input wire logic        write_hit_copyback,
  input wire logic        hit_update,
  input wire logic        hit_set_modified,
  input wire logic        push_req,
  input wire logic        push_modified,
  input wire logic        push_keeps_line_valid,
  input wire logic        push_writeback,
  input wire logic        push_invalidate,
  input wire logic        core_write,
  input wire logic        write_imprecise,
  input wire logic        write_inhibited,
  input wire logic        store_enqueue,
  input wire logic        direct_bus_write
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // An allocation request that the enabled cache must answer.
  wire take = alloc_req && cache_enable;
  // Lowest free way of a set, the unlocked choice.
  function automatic logic [1:0] low_free(logic [3:0] v);
    return !v[0] ? WAY_0 : !v[1] ? WAY_1 : !v[2] ? WAY_2 : WAY_3;
  endfunction : low_free
  a_lock_upper_only: assert property (take && half_way_lock |=> alloc_ack && alloc_way[1])
    else $error("locked allocation used way 0 or 1");
  a_lock_way2_first: assert property (take && half_way_lock && !alloc_valid[2] |=> alloc_way == WAY_2)
    else $error("locked allocation skipped free way 2");
  a_free_lowest: assert property (take && !half_way_lock && alloc_valid != 4'hF
    |=> alloc_way == low_free($past(alloc_valid))) else $error("lowest free way not used");
  a_off_no_ack: assert property (alloc_req && !cache_enable |=> !alloc_ack)
    else $error("disabled cache answered allocation");
  a_reset_clear: assert property ($fell(rst) |-> debug_rdata == 32'h0)
    else $error("control register not cleared by reset");
  a_hit_update: assert property (write_hit && cache_enable |=> hit_update
    && hit_update_way == $past(write_hit_way)
    && hit_set_modified == $past(write_hit_copyback)) else $error("write hit not applied");
  a_push_answer: assert property (push_req |=> push_writeback == $past(push_modified)
    && push_invalidate == !$past(push_keeps_line_valid)) else $error("line push answer wrong");
  a_precise_bypass: assert property (core_write && write_inhibited && !write_imprecise
    |=> direct_bus_write && !store_enqueue) else $error("precise write entered store buffer");
  c_locked_full: cover property (take && half_way_lock && alloc_valid[3:2] == 2'h3);
  c_push_keep: cover property (push_req && push_keeps_line_valid);
  c_off_req: cover property (alloc_req && !cache_enable);
endmodule : way_ctl_props
bind cache_way_lock_and_control way_ctl_props chk_u (.*);
`default_nettype wire

//--- bus_side_model.sv
`timescale 1ns/1ps
`default_nettype none
// Stands for the system bus: retires queued writes and ends line pushes.
module bus_side_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       push_buffer_write,
  input  wire logic       hold,
  input  wire logic [2:0] store_count,
  input  wire logic [3:0] delay,
  output logic            push_bus_done,
  output logic            store_retire
);
  logic [3:0] wait_reg; // Cycles spent on the current line write.
  // A line write ends after the chosen delay, so the bus can be prompt or slow.
  always_ff @(posedge clk) begin
    if (rst || !push_buffer_write || push_bus_done) begin
      wait_reg      <= 4'h0;
      push_bus_done <= 1'h0;
    end else begin
      wait_reg      <= wait_reg + 4'h1;
      push_bus_done <= (wait_reg == delay);
    end
  end
  // Queued writes retire every other cycle unless the bench holds the bus.
  always_ff @(posedge clk) begin
    store_retire <= !rst && !hold && store_count != 3'h0 && !store_retire;
  end
endmodule : bus_side_model
`default_nettype wire

//--- cache_way_lock_and_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module cache_way_lock_and_control_bench;
  import way_lock_pkg::*;
  logic        clk, rst, ctl_move_write, debug_write, alloc_req, write_hit, write_hit_copyback;
  logic        push_req, push_modified, victim_modified, fill_done, core_write, write_imprecise;
  logic        write_through, write_inhibited, push_bus_done, store_retire, hold, lk, k;
  logic [31:0] ctl_move_data, debug_wdata, debug_rdata;
  logic [3:0]  alloc_valid, delay;
  logic [1:0]  write_hit_way, push_way, alloc_way, hit_update_way, push_out_way, rr, w;
  logic        alloc_ack, hit_update, hit_set_modified, push_writeback, push_invalidate;
  logic        push_buffer_valid, push_buffer_write, store_enqueue, direct_bus_write, core_stall;
  logic [2:0]  store_count;
  logic        cache_enable, store_buffer_enable, push_keeps_line_valid, half_way_lock;
  int          num_errors = 0, samples_checked = 0, seed = 97574;
  cache_way_lock_and_control dut_u (.*);
  bus_side_model bus_u (.*);
  // Free-running clock of 4 ns.
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Compares one value and reports a mismatch at once.
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // Way the cache should pick for a set, from the bench copy of the counter.
  function automatic logic [1:0] exp_way(logic [3:0] v, logic l, logic [1:0] c);
    if (l) return !v[2] ? WAY_2 : !v[3] ? WAY_3 : c[1] ? WAY_3 : WAY_2;
    return !v[0] ? WAY_0 : !v[1] ? WAY_1 : !v[2] ? WAY_2 : !v[3] ? WAY_3 : c;
  endfunction : exp_way
  // Writes the control register through the move or the debug port.
  task automatic wr(logic dbg, logic [31:0] d);
    @(negedge clk);
    ctl_move_write = !dbg;
    debug_write = dbg;
    ctl_move_data = d;
    debug_wdata = d;
    @(negedge clk);
    ctl_move_write = 1'h0;
    debug_write = 1'h0;
  endtask : wr
  // Requests one allocation, checks the answer and advances the bench copy of the counter.
  task automatic alloc(logic [3:0] v);
    @(negedge clk);
    alloc_req = 1'h1;
    alloc_valid = v;
    @(negedge clk);
    alloc_req = 1'h0;
    chk({alloc_ack, alloc_way}, {1'h1, exp_way(v, lk, rr)});
    if (lk && v[3:2] == 2'h3 && rr[1]) rr[0] = !rr[0];
    else if (!lk && v == 4'hF) rr = rr + 2'h1;
  endtask : alloc
  // Offers one core write; exp is enqueue, direct write and stall.
  task automatic cw(logic imp, logic wt, logic inh, logic [2:0] exp);
    @(negedge clk);
    core_write = 1'h1;
    {write_imprecise, write_through, write_inhibited} = {imp, wt, inh};
    @(negedge clk);
    core_write = 1'h0;
    chk({store_enqueue, direct_bus_write, core_stall}, exp);
  endtask : cw
  // Cuts a hung run short.
  initial begin
    #60000;
    num_errors++;
    end_sim();
  end
  // Main sequence of tests.
  initial begin
    {ctl_move_write, debug_write, alloc_req, write_hit, write_hit_copyback, push_req} = '0;
    {push_modified, victim_modified, fill_done, core_write, write_imprecise} = '0;
    {write_through, write_inhibited, ctl_move_data, debug_wdata, alloc_valid} = '0;
    {write_hit_way, push_way, lk} = '0;
    {rst, hold, delay, rr} = {2'h3, 4'h2, ROUND_ROBIN_RESET};
    repeat (16) @(negedge clk);
    rst = 1'h0;
    chk(debug_rdata, CONTROL_RESET);
    @(negedge clk);
    alloc_req = 1'h1;
    @(negedge clk);
    alloc_req = 1'h0;
    chk(alloc_ack, 1'h0);
    wr(1'h1, 32'hBFFF_FFFF);
    chk(debug_rdata, 32'hB800_0000);
    chk({cache_enable, store_buffer_enable, push_keeps_line_valid, half_way_lock}, 4'hF);
    $display("register test done");
    lk = 1'h1;
    alloc(4'h3);
    alloc(4'h7);
    for (int i = 0; i < 300; i++) begin
      if (i % 8 == 0) begin
        lk = $random(seed);
        wr(1'h0, {1'h1, 3'h0, lk, 27'h0});
      end
      alloc($random(seed));
    end
    $display("allocation test done");
    for (int i = 0; i < 20; i++) begin
      k = $random(seed);
      wr(1'h0, {1'h1, 2'h0, k, 1'h1, 27'h0});
      {w, write_hit_copyback, push_modified} = $random(seed);
      @(negedge clk);
      {write_hit, push_req, write_hit_way, push_way} = {2'h3, w, ~w};
      @(negedge clk);
      {write_hit, push_req} = 2'h0;
      chk({hit_update, hit_update_way, hit_set_modified}, {1'h1, w, write_hit_copyback});
      chk({push_writeback, push_invalidate, push_out_way}, {push_modified, !k, ~w});
    end
    $display("hit and push test done");
    wr(1'h0, 32'hA000_0000);
    for (int i = 0; i < 5; i++) cw(1'h1, 1'h1, 1'h0, i < 4 ? 3'h4 : 3'h1);
    chk(store_count, 3'h4);
    cw(1'h0, 1'h0, 1'h1, 3'h2);
    hold = 1'h0;
    for (int i = 0; i < 40 && store_count !== 3'h0; i++) @(negedge clk);
    chk(store_count, 3'h0);
    wr(1'h0, 32'h8000_0000);
    cw(1'h1, 1'h1, 1'h0, 3'h2);
    $display("store path test done");
    {lk, delay, victim_modified} = {1'h0, 4'h9, 1'h1};
    alloc(4'h0);
    victim_modified = 1'h0;
    chk({push_buffer_valid, push_buffer_write}, 2'h2);
    repeat (3) @(negedge clk);
    fill_done = 1'h1;
    @(negedge clk);
    fill_done = 1'h0;
    chk({push_buffer_valid, push_buffer_write}, 2'h3);
    for (int i = 0; i < 40 && push_buffer_write !== 1'h0; i++) @(negedge clk);
    chk({push_buffer_valid, push_buffer_write}, 2'h0);
    $display("eviction test done");
    end_sim();
  end
endmodule : cache_way_lock_and_control_bench
`default_nettype wire
